// ### src/ciu_defs.svh
// constants of the control instruction unit: opcodes, fields, widths
// assumes a single-parcel 16-bit instruction word from the issue logic
`ifndef CIU_DEFS_SVH
`define CIU_DEFS_SVH

// instruction field positions (7-bit opcode, then i, j, k)
`define CIU_OP_MSB 15
`define CIU_OP_LSB 9
`define CIU_I_MSB 8
`define CIU_I_LSB 6
`define CIU_J_MSB 5
`define CIU_J_LSB 3
`define CIU_K_MSB 2
`define CIU_K_LSB 0

// opcodes handled here
`define CIU_OP_ERR 7'h00
`define CIU_OP_SPECIAL 7'h01
`define CIU_OP_VLEN 7'h02
`define CIU_OP_VMASK 7'h03
`define CIU_OP_NEXIT 7'h04
`define CIU_OP_BRANCH 7'h05

// i field functions of the special opcode
`define CIU_FN_CUR 3'h0
`define CIU_FN_LIM 3'h1
`define CIU_FN_CLR 3'h2
`define CIU_FN_XA 3'h3
`define CIU_FN_RTC 3'h4

// channel number range that channel functions accept
`define CIU_CHAN_MIN 2
`define CIU_CHAN_MAX 25

// flag register bit positions
`define CIU_FLAG_ERR_BIT 0
`define CIU_FLAG_NEXIT_BIT 1

// reset values
`define CIU_VL_RST 7'h00
`define CIU_VL_EFF_RST 7'h40
`define CIU_XA_RST 8'h00

`endif

// ### src/ciu_pkg.sv
// types of the control instruction unit
// assumes ciu_defs.svh holds every numeric constant
package ciu_pkg;
  typedef enum logic [1:0] {
    CIU_IDLE,
    CIU_DRAIN,
    CIU_EXCH
  } ciu_state_t;
endpackage : ciu_pkg

// ### src/ciu_chan_mem.sv
// per-channel current and limit address store with registered read
// assumes one write port and one registered read port, same clock
`timescale 1ns/1ps
`default_nettype none
module ciu_chan_mem #(
  parameter int unsigned N_CHAN = 32,
  parameter int unsigned AW = 24
) (
  // clock
  input wire logic ref_clk_i,
  // write port
  input wire logic we_i,
  input wire logic [$clog2(N_CHAN)-1:0] waddr_i,
  input wire logic [AW-1:0] wdata_i,
  // read port
  input wire logic [$clog2(N_CHAN)-1:0] raddr_i,
  output logic [AW-1:0] rdata_o
);
  logic [AW-1:0] mem [N_CHAN];
  logic [AW-1:0] rdata_q;

  if (N_CHAN < 2) begin : g_bad_nchan
    $error("ciu_chan_mem: N_CHAN too small");
  end

  // memory contents are undefined until software loads them
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_q <= mem[raddr_i];
  end

  assign rdata_o = rdata_q;
endmodule : ciu_chan_mem
`default_nettype wire

// ### src/ciu_top.sv
// control instruction unit: exits, channel setup, xa/rtc/vl/vm loads,
// register-indirect branch
// assumes issue logic presents one instruction per valid pulse with its
// operands already read, and reports when earlier results have arrived
//
// Notes on behaviour
// RULE_01: opcode 000 is an error condition and causes an exchange jump.
// RULE_02: exchange jump from either exit voids the instruction buffers.
// RULE_03: error exit sets error flag outside monitor mode, nothing inside.
// RULE_04: exits wait for earlier results, then exchange to package at xa.
// RULE_05: saved program address is exit address plus one.
// RULE_06: opcode 001 is a pass outside monitor mode or i of 5, 6, 7.
// RULE_07: i of 0, 1, 2 loads current, loads limit, clears channel flags.
// RULE_08: current load starts channel; address steps to limit then stops.
// RULE_09: channel functions pass if j zero or channel outside 2..25.
// RULE_10: k zero loads the value one into current or limit address.
// RULE_11: i of 3 loads exchange address from a j; j zero clears it.
// RULE_12: clock load takes scalar j; register zero clears the clock.
// RULE_13: opcode 002 loads vector length from low seven bits of a k.
// RULE_14: effective length is one plus low six bits of length minus one.
// RULE_15: opcode 002 with k zero sets vector length to one.
// RULE_16: opcode 003 copies scalar j to mask; j zero clears the mask.
// RULE_17: opcode 004 exchanges; sets normal exit flag outside monitor.
// RULE_18: low nine bits of opcode 004 are ignored request code.
// RULE_19: opcode 005 branches to parcel address held in selected b reg.
// RULE_20: i of 0 current, 1 limit, 2 flag clear, 4 clock load.
// RULE_21: parcel is 7-bit opcode then i, j, k; jk is a 6-bit field.
`timescale 1ns/1ps
`default_nettype none
`include "ciu_defs.svh"
module ciu_top
  import ciu_pkg::*;
#(
  parameter int unsigned AW = 24,
  parameter int unsigned SW = 64,
  parameter int unsigned N_CHAN = 32
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // issued instruction and its operands
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [AW-1:0] instr_addr_i,
  input wire logic [AW-1:0] address_operand_j_i,
  input wire logic [AW-1:0] address_operand_k_i,
  input wire logic [SW-1:0] scalar_operand_j_i,
  input wire logic [AW-1:0] b_operand_jk_i,
  input wire logic monitor_mode_i,
  input wire logic results_done_i,
  // channel activity
  input wire logic chan_step_i,
  input wire logic [$clog2(N_CHAN)-1:0] chan_step_sel_i,
  // exchange and branch
  output logic exch_req_o,
  output logic [AW-1:0] exch_pkg_addr_o,
  output logic [AW-1:0] exch_saved_p_o,
  output logic buf_void_o,
  output logic busy_o,
  output logic branch_o,
  output logic [AW-1:0] branch_addr_o,
  // operating and supporting registers
  output logic [1:0] flag_o,
  output logic [AW-1:0] exchange_address_reg_o,
  output logic [SW-1:0] rtc_o,
  output logic [6:0] vector_length_reg_o,
  output logic [6:0] vector_length_eff_o,
  output logic [SW-1:0] vector_mask_reg_o,
  // channels
  output logic [N_CHAN-1:0] chan_active_o,
  output logic [N_CHAN-1:0] chan_flag_clear_o,
  output logic [AW-1:0] chan_current_o
);
  // all state of the unit; the channel stores keep their own read register
  typedef struct packed {
    ciu_state_t st;
    logic [AW-1:0] saved_p;
    logic exch_req;
    logic buf_void;
    logic branch;
    logic [AW-1:0] branch_addr;
    logic [1:0] flag;
    logic [AW-1:0] xa;
    logic [SW-1:0] rtc;
    logic [6:0] vl;
    logic [6:0] vl_eff;
    logic [SW-1:0] vm;
    logic [N_CHAN-1:0] active;
    logic [N_CHAN-1:0] fclr;
    logic busy;
    logic step;
    logic [$clog2(N_CHAN)-1:0] step_sel;
    logic [AW-1:0] cur_o;
  } ciu_regs_t;

  localparam int unsigned CW = $clog2(N_CHAN);

  // channel numbers up to 25 must index a channel, vl takes seven a k bits
  if (N_CHAN <= `CIU_CHAN_MAX) begin : g_bad_nchan
    $error("ciu_top: N_CHAN too small");
  end
  if (AW < 7) begin : g_bad_aw
    $error("ciu_top: AW too small");
  end

  ciu_regs_t r_q, r_d;

  ////////////////////////////////////////////////////////////////////////
  // field decode
  logic [6:0] op;
  logic [2:0] fi, fj, fk;
  logic [5:0] fjk;
  assign op = instr_i[`CIU_OP_MSB:`CIU_OP_LSB]; // RULE_21
  assign fi = instr_i[`CIU_I_MSB:`CIU_I_LSB];
  assign fj = instr_i[`CIU_J_MSB:`CIU_J_LSB];
  assign fk = instr_i[`CIU_K_MSB:`CIU_K_LSB];
  assign fjk = {fj, fk}; // RULE_21

  // channel number check on the a j operand
  logic chan_ok;
  assign chan_ok = (fj != 3'h0) &&
    (address_operand_j_i >= AW'(`CIU_CHAN_MIN)) &&
    (address_operand_j_i <= AW'(`CIU_CHAN_MAX)); // RULE_09

  logic [AW-1:0] chan_val;
  assign chan_val = (fk == 3'h0) ? AW'(1) : address_operand_k_i; // RULE_10

  logic spec_ok;
  // taken only while idle, so a stray 001 during a drain writes no store
  assign spec_ok = instr_valid_i && (op == `CIU_OP_SPECIAL) &&
    monitor_mode_i && (r_q.st == CIU_IDLE); // RULE_06

  logic cur_we, lim_we;
  assign cur_we = spec_ok && (fi == `CIU_FN_CUR) && chan_ok; // RULE_20
  assign lim_we = spec_ok && (fi == `CIU_FN_LIM) && chan_ok; // RULE_20
  logic [CW-1:0] sel;
  assign sel = address_operand_j_i[CW-1:0];

  ////////////////////////////////////////////////////////////////////////
  // channel address stores: current steps, limit is compared on read
  logic [AW-1:0] cur_rd, lim_rd, cur_wdata;
  logic step_we;
  logic [CW-1:0] cur_waddr;
  logic [AW-1:0] cur_rd_d;
  // a step reads both stores one cycle, then writes the incremented value;
  // steps closer than two cycles on one channel would read a stale word,
  // and a current load takes the single write port, so a step that
  // coincides with it is dropped
  assign step_we = r_q.step && r_q.active[r_q.step_sel] &&
    (cur_rd != lim_rd) && !cur_we;
  assign cur_waddr = cur_we ? sel : r_q.step_sel;
  assign cur_rd_d = cur_rd + AW'(1);
  assign cur_wdata = cur_we ? chan_val : cur_rd_d; // RULE_08

  ciu_chan_mem #(.N_CHAN(N_CHAN), .AW(AW)) u_cur (
    .ref_clk_i(ref_clk_i),
    .we_i(cur_we || step_we),
    .waddr_i(cur_waddr),
    .wdata_i(cur_wdata),
    .raddr_i(chan_step_sel_i),
    .rdata_o(cur_rd)
  );

  ciu_chan_mem #(.N_CHAN(N_CHAN), .AW(AW)) u_lim (
    .ref_clk_i(ref_clk_i),
    .we_i(lim_we),
    .waddr_i(sel),
    .wdata_i(chan_val),
    .raddr_i(chan_step_sel_i),
    .rdata_o(lim_rd)
  );

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  logic [6:0] vl_new;
  logic [5:0] vl_m1;
  always_comb begin
    r_d = r_q;
    vl_new = r_q.vl;
    vl_m1 = 6'h00;
    r_d.buf_void = 1'b0;
    r_d.exch_req = 1'b0;
    r_d.branch = 1'b0;
    r_d.fclr = '0;
    // step request and read-out pipeline track the registered store reads
    r_d.step = chan_step_i;
    r_d.step_sel = chan_step_sel_i;
    r_d.cur_o = cur_rd;
    // free-running real time clock, overridden by a load below
    r_d.rtc = r_q.rtc + SW'(1);
    case (r_q.st)
      CIU_IDLE: begin
        if (instr_valid_i) begin
          case (op)
            `CIU_OP_ERR, `CIU_OP_NEXIT: begin // RULE_01 RULE_17
              // low nine bits of a normal exit carry no meaning here
              r_d.saved_p = instr_addr_i + AW'(1); // RULE_05 RULE_18
              if (!monitor_mode_i) begin // RULE_03
                if (op == `CIU_OP_ERR) begin
                  r_d.flag[`CIU_FLAG_ERR_BIT] = 1'b1; // RULE_03
                end else begin
                  r_d.flag[`CIU_FLAG_NEXIT_BIT] = 1'b1; // RULE_17
                end
              end
              r_d.st = CIU_DRAIN; // RULE_04
            end
            `CIU_OP_SPECIAL: begin
              if (spec_ok) begin
                case (fi)
                  `CIU_FN_CUR: begin
                    if (chan_ok) r_d.active[sel] = 1'b1; // RULE_08
                  end
                  `CIU_FN_CLR: begin
                    if (chan_ok) r_d.fclr[sel] = 1'b1; // RULE_07
                  end
                  `CIU_FN_XA: begin
                    r_d.xa = (fj == 3'h0) ? '0 :
                      address_operand_j_i; // RULE_11
                  end
                  `CIU_FN_RTC: begin
                    r_d.rtc = (fj == 3'h0) ? '0 :
                      scalar_operand_j_i; // RULE_12
                  end
                  default: begin
                  end
                endcase
              end
            end
            `CIU_OP_VLEN: begin
              vl_new = (fk == 3'h0) ? 7'h01 :
                address_operand_k_i[6:0]; // RULE_13 RULE_15
              r_d.vl = vl_new;
            end
            `CIU_OP_VMASK: begin
              r_d.vm = (fj == 3'h0) ? '0 : scalar_operand_j_i; // RULE_16
            end
            `CIU_OP_BRANCH: begin
              r_d.branch = 1'b1; // RULE_19
              r_d.branch_addr = b_operand_jk_i;
            end
            default: begin
            end
          endcase
        end
      end
      CIU_DRAIN: begin
        // earlier issued instructions must deliver results first
        if (results_done_i) begin
          r_d.st = CIU_EXCH; // RULE_04
        end
      end
      CIU_EXCH: begin
        r_d.exch_req = 1'b1; // RULE_04
        r_d.buf_void = 1'b1; // RULE_02
        r_d.st = CIU_IDLE;
      end
      default: r_d.st = CIU_IDLE;
    endcase
    // channel stops once current meets limit
    if (r_q.step && r_q.active[r_q.step_sel] && (cur_rd == lim_rd) &&
        !(cur_we && sel == r_q.step_sel)) begin
      r_d.active[r_q.step_sel] = 1'b0; // RULE_08
    end
    // busy is registered so the port comes straight from a flop
    r_d.busy = (r_d.st != CIU_IDLE); // RULE_04
    // effective length from the stored value
    vl_m1 = 6'(r_d.vl - 7'h01);
    r_d.vl_eff = {1'b0, vl_m1} + 7'h01; // RULE_14
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r_q <= '0;
      r_q.st <= CIU_IDLE;
      r_q.vl <= `CIU_VL_RST;
      r_q.vl_eff <= `CIU_VL_EFF_RST;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign exch_req_o = r_q.exch_req;
  assign exch_pkg_addr_o = r_q.xa; // RULE_04
  assign exch_saved_p_o = r_q.saved_p;
  assign buf_void_o = r_q.buf_void;
  assign busy_o = r_q.busy;
  assign branch_o = r_q.branch;
  assign branch_addr_o = r_q.branch_addr;
  assign flag_o = r_q.flag;
  assign exchange_address_reg_o = r_q.xa; // RULE_11
  assign rtc_o = r_q.rtc; // RULE_12
  assign vector_length_reg_o = r_q.vl;
  assign vector_length_eff_o = r_q.vl_eff;
  assign vector_mask_reg_o = r_q.vm;
  assign chan_active_o = r_q.active;
  assign chan_flag_clear_o = r_q.fclr;
  assign chan_current_o = r_q.cur_o;
endmodule : ciu_top
`default_nettype wire

// ### sim/ciu_top_asserts.sv
// checker for the control instruction unit, bound to ciu_top
// assumes single clock and sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module ciu_top_asserts #(
  parameter int unsigned AW = 24,
  parameter int unsigned SW = 64,
  parameter int unsigned N_CHAN = 32
) (
  // clock, reset and issue side
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [AW-1:0] instr_addr_i,
  input wire logic [AW-1:0] address_operand_j_i,
  input wire logic [AW-1:0] address_operand_k_i,
  input wire logic [SW-1:0] scalar_operand_j_i,
  input wire logic [AW-1:0] b_operand_jk_i,
  input wire logic monitor_mode_i,
  input wire logic results_done_i,
  // outputs watched
  input wire logic exch_req_o,
  input wire logic [AW-1:0] exch_pkg_addr_o,
  input wire logic [AW-1:0] exch_saved_p_o,
  input wire logic buf_void_o,
  input wire logic busy_o,
  input wire logic branch_o,
  input wire logic [AW-1:0] branch_addr_o,
  input wire logic [1:0] flag_o,
  input wire logic [AW-1:0] exchange_address_reg_o,
  input wire logic [6:0] vector_length_reg_o,
  input wire logic [6:0] vector_length_eff_o,
  input wire logic [SW-1:0] vector_mask_reg_o,
  input wire logic [N_CHAN-1:0] chan_flag_clear_o
);
  ////////////////////////////////////////
  // decode of the parcel as the issue logic sees it
  logic acc, mon1, cok;
  logic [6:0] op;
  logic [2:0] i, j, k;
  assign acc = instr_valid_i && !busy_o;
  assign op = instr_i[15:9];
  assign i = instr_i[8:6];
  assign j = instr_i[5:3];
  assign k = instr_i[2:0];
  assign mon1 = acc && op == 7'h01 && monitor_mode_i;
  assign cok = i == 3'h2 && j != 3'h0 && address_operand_j_i >= 2
    && address_operand_j_i <= 25;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  a_vl_load: assert property (acc && op == 7'h02 |=>
    vector_length_reg_o == ($past(k) == 3'h0 ? 7'h01 :
    $past(address_operand_k_i[6:0]))) else $error("vl load wrong");
  a_vl_effect: assert property (vector_length_eff_o ==
    7'(((vector_length_reg_o - 7'h01) & 7'h3f) + 7'h01))
    else $error("effective length wrong");
  a_vm_load: assert property (acc && op == 7'h03 |=>
    vector_mask_reg_o == ($past(j) == 3'h0 ? '0 :
    $past(scalar_operand_j_i))) else $error("mask load wrong");
  a_xa_load: assert property (mon1 && i == 3'h3 |=>
    exchange_address_reg_o == ($past(j) == 3'h0 ? '0 :
    $past(address_operand_j_i))) else $error("xa load wrong");
  a_exch_after_drain: assert property (exch_req_o |->
    buf_void_o && $past(results_done_i, 2) && !busy_o && $past(busy_o) &&
    exch_pkg_addr_o == exchange_address_reg_o) else $error("bad exchange");
  a_saved_p: assert property (acc && (op == 7'h00 || op == 7'h04) |=>
    exch_saved_p_o == $past(instr_addr_i) + 1'b1) else $error("saved p");
  a_err_flag: assert property (acc && op == 7'h00 |=>
    flag_o == ($past(flag_o) | {1'b0, !$past(monitor_mode_i)}))
    else $error("error exit flag wrong");
  a_nexit_flag: assert property (acc && op == 7'h04 |=>
    flag_o == ($past(flag_o) | {!$past(monitor_mode_i), 1'b0}))
    else $error("normal exit flag wrong");
  a_branch_addr: assert property (acc && op == 7'h05 |=>
    branch_o && branch_addr_o == $past(b_operand_jk_i))
    else $error("branch wrong");
  a_chan_clear: assert property (acc && op == 7'h01 |=>
    chan_flag_clear_o == ($past(cok && monitor_mode_i) ?
    N_CHAN'(1) << $past(address_operand_j_i[4:0]) : '0))
    else $error("flag clear pulse wrong");
endmodule : ciu_top_asserts
`default_nettype wire

// ### sim/ciu_issue_model.sv
// model of the issue logic's drain: reports earlier results done
// assumes busy_i high while the unit waits before an exchange
`timescale 1ns/1ps
`default_nettype none
module ciu_issue_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // drain handshake
  input wire logic busy_i,
  input wire logic [3:0] lat_i,
  output logic results_done_o
);
  ////////////////////////////////////////
  logic [3:0] cnt_q;
  // results land lat_i cycles into the drain, never earlier
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !busy_i) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hf) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign results_done_o = busy_i && (cnt_q >= lat_i);
endmodule : ciu_issue_model
`default_nettype wire

// ### sim/ciu_top_tb_top.sv
// testbench of the control instruction unit
// assumes default parameters: 24-bit addresses, 32 channels
`timescale 1ns/1ps
`default_nettype none
module ciu_top_tb_top;
  logic ref_clk_i = 0, rst_i = 1, instr_valid_i = 0, monitor_mode_i = 0;
  logic chan_step_i = 0, results_done_i, exch_req_o, buf_void_o, busy_o;
  logic branch_o;
  logic [15:0] instr_i = '0;
  logic [23:0] instr_addr_i = '0, address_operand_j_i = '0;
  logic [23:0] address_operand_k_i = '0, b_operand_jk_i = '0;
  logic [23:0] exch_pkg_addr_o, exch_saved_p_o, branch_addr_o;
  logic [23:0] exchange_address_reg_o, chan_current_o;
  logic [63:0] scalar_operand_j_i = '0, rtc_o, vector_mask_reg_o;
  logic [4:0] chan_step_sel_i = '0;
  logic [3:0] lat = 4'h0;
  logic [1:0] flag_o;
  logic [6:0] vector_length_reg_o, vector_length_eff_o;
  logic [31:0] chan_active_o, chan_flag_clear_o;
  int num_errors = 0, checks = 0;
  ciu_top i_dut (.ref_clk_i, .rst_i, .instr_valid_i, .instr_i,
    .instr_addr_i, .address_operand_j_i, .address_operand_k_i,
    .scalar_operand_j_i, .b_operand_jk_i, .monitor_mode_i,
    .results_done_i, .chan_step_i, .chan_step_sel_i, .exch_req_o,
    .exch_pkg_addr_o, .exch_saved_p_o, .buf_void_o, .busy_o, .branch_o,
    .branch_addr_o, .flag_o, .exchange_address_reg_o, .rtc_o,
    .vector_length_reg_o, .vector_length_eff_o, .vector_mask_reg_o,
    .chan_active_o, .chan_flag_clear_o, .chan_current_o);
  ciu_issue_model i_iss (.ref_clk_i, .rst_i, .busy_i(busy_o), .lat_i(lat),
    .results_done_o(results_done_i));
  // free-running clock
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [15:0] pc(int o, int i, int j, int k);
    return {7'(o), 3'(i), 3'(j), 3'(k)};
  endfunction : pc
  // one issue pulse; operands held with it, outputs settled on return
  task automatic iss(logic [15:0] w, logic [23:0] a, logic [23:0] b,
      logic [63:0] s, logic m);
    @(posedge ref_clk_i);
    instr_valid_i <= 1;
    instr_i <= w;
    instr_addr_i <= a;
    address_operand_j_i <= a;
    address_operand_k_i <= b;
    b_operand_jk_i <= b;
    scalar_operand_j_i <= s;
    monitor_mode_i <= m;
    @(posedge ref_clk_i);
    instr_valid_i <= 0;
    #1;
  endtask : iss
  // exit at address a, then wait bounded for the exchange pulse
  task automatic ex(logic [15:0] w, logic [23:0] a, logic m, logic [1:0] f);
    int n;
    iss(w, a, 0, 0, m);
    chk("busy", 1, busy_o);
    for (n = 0; n < 30 && exch_req_o !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk("exch_delay", lat + 2, n);
    chk("exch_req", 1, exch_req_o);
    chk("buf_void", 1, buf_void_o);
    chk("saved_p", a + 24'h1, exch_saved_p_o);
    chk("pkg_addr", 24'h0000a0, exch_pkg_addr_o);
    chk("flag", f, flag_o);
  endtask : ex
  // channel step on channel 5, then wait out the read latency
  task automatic step();
    @(posedge ref_clk_i);
    chan_step_i <= 1;
    chan_step_sel_i <= 5'h05;
    @(posedge ref_clk_i);
    chan_step_i <= 0;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask : step
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #8000;
    num_errors++;
    wrap_up();
  end
  initial begin
    static logic [23:0] vt [4] = '{24'h0000c5, 24'h000040, 24'h0, 24'h7};
    static logic [6:0] vx [4] = '{7'h45, 7'h40, 7'h00, 7'h01};
    static logic [6:0] ve [4] = '{7'h05, 7'h40, 7'h40, 7'h01};
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 0;
    #1;
    chk("eff_reset", 64, vector_length_eff_o);
    for (int n = 0; n < 4; n++) begin
      iss(pc(2, 0, 0, n == 3 ? 0 : 2), 0, vt[n], 0, 0);
      chk("vl", vx[n], vector_length_reg_o);
      chk("vl_eff", ve[n], vector_length_eff_o);
    end
    $display("vector length done");
    iss(pc(3, 0, 2, 0), 0, 0, 64'h0123456789abcdef, 0);
    chk("vm", 64'h0123456789abcdef, vector_mask_reg_o);
    iss(pc(3, 0, 0, 0), 0, 0, 64'h5, 0);
    chk("vm_clear", 0, vector_mask_reg_o);
    iss(pc(5, 0, 1, 7), 0, 24'h00abcd, 0, 0);
    chk("branch", 24'h00abcd, branch_o ? branch_addr_o : '0);
    $display("mask and branch done");
    iss(pc(1, 3, 1, 0), 24'h000055, 0, 0, 0);
    chk("xa_user", 0, exchange_address_reg_o);
    iss(pc(1, 3, 1, 0), 24'h0000a0, 0, 0, 1);
    chk("xa", 24'h0000a0, exchange_address_reg_o);
    iss(pc(1, 4, 0, 0), 0, 0, 64'h77, 1);
    chk("rtc_clear", 0, rtc_o);
    iss(pc(1, 4, 2, 0), 0, 0, 64'h77, 1);
    chk("rtc_load", 64'h77, rtc_o);
    $display("monitor loads done");
    iss(pc(1, 1, 1, 2), 24'h5, 24'h3, 0, 1);
    iss(pc(1, 0, 1, 0), 24'h5, 24'h9, 0, 1);
    chk("active", 1, chan_active_o[5]);
    iss(pc(1, 0, 1, 2), 24'h1, 24'h9, 0, 1);
    iss(pc(1, 0, 1, 2), 24'h1a, 24'h9, 0, 1);
    iss(pc(1, 5, 1, 2), 24'h6, 24'h9, 0, 1);
    iss(pc(1, 0, 0, 2), 24'h7, 24'h9, 0, 1);
    chk("refused", 32'h20, chan_active_o);
    iss(pc(1, 2, 1, 0), 24'h5, 0, 0, 1);
    chk("flag_clear", 32'h20, chan_flag_clear_o);
    repeat (3) step();
    chk("current", 24'h3, chan_current_o);
    chk("ended", 0, chan_active_o[5]);
    $display("channels done");
    ex(pc(0, 0, 0, 0), 24'h000100, 1, 2'h0);
    lat <= 4'h5;
    ex(16'h09ff, 24'h000200, 0, 2'h2);
    ex(pc(0, 0, 0, 0), 24'h000300, 0, 2'h3);
    $display("exits done");
    wrap_up();
  end
endmodule : ciu_top_tb_top
bind ciu_top ciu_top_asserts #(.AW(AW), .SW(SW), .N_CHAN(N_CHAN)) i_chk (
  .ref_clk_i, .rst_i, .instr_valid_i, .instr_i, .instr_addr_i,
  .address_operand_j_i, .address_operand_k_i, .scalar_operand_j_i,
  .b_operand_jk_i, .monitor_mode_i, .results_done_i, .exch_req_o,
  .exch_pkg_addr_o, .exch_saved_p_o, .buf_void_o, .busy_o, .branch_o,
  .branch_addr_o, .flag_o, .exchange_address_reg_o, .vector_length_reg_o,
  .vector_length_eff_o, .vector_mask_reg_o, .chan_flag_clear_o);
`default_nettype wire
